// File: hdl/slpc_pkg.sv
package slpc_pkg;

  localparam int          CLK_HZ           = 50_000_000;
  localparam int          PARTIAL_EXIT_NS  = 10;
  localparam int          SLUMBER_EXIT_MS  = 10;
  localparam int          DEVSLP_EXIT_MS   = 20;
  localparam int          CYC_PER_MS       = CLK_HZ / 1000;
  localparam int          PARTIAL_EXIT_RAW = (PARTIAL_EXIT_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int          PARTIAL_EXIT_CYC = (PARTIAL_EXIT_RAW < 1) ? 1 : PARTIAL_EXIT_RAW;
  localparam int          SLUMBER_EXIT_CYC = SLUMBER_EXIT_MS * CYC_PER_MS;
  localparam int          DEVSLP_EXIT_CYC  = DEVSLP_EXIT_MS * CYC_PER_MS;
  localparam int          DEVSLP_IDLE_CYC  = 256;
  localparam int          CNT_W            = 24;

  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_PGATE  = 8'h04;
  localparam logic [7:0]  OFS_LSTATE = 8'h08;
  localparam logic [7:0]  OFS_HPSTAT = 8'h0c;
  localparam logic [7:0]  OFS_CMD    = 8'h10;
  localparam logic [7:0]  OFS_CAP    = 8'h14;
  localparam logic [7:0]  OFS_DSEXIT = 8'h18;
  localparam logic [7:0]  OFS_PMCSR  = 8'h1c;

  localparam int          CTRL_RAID_MODE     = 0;
  localparam int          CTRL_RAID_AHCI_OVR = 1;
  localparam int          CTRL_LOW_POWER     = 2;
  localparam int          CTRL_HIPM          = 3;
  localparam int          CTRL_DIPM          = 4;
  localparam int          CTRL_DEVSLP_AUTO   = 5;
  localparam int          CTRL_W             = 6;
  localparam int          HP_PRES_LSB        = 8;
  localparam int          HP_TMO_LSB         = 16;
  localparam int          CAP_RAID_AVAIL     = 3;
  localparam logic [2:0]  CAP_SPEEDS         = 3'h7;
  localparam logic [1:0]  PM_D0              = 2'h0;
  localparam logic [1:0]  PM_D3              = 2'h3;
  localparam int          LST_W              = 3;

  typedef enum logic [6:0] {
    LP_ACT  = 7'h01,
    LP_PART = 7'h02,
    LP_SLUM = 7'h04,
    LP_DSLP = 7'h08,
    LP_WK_P = 7'h10,
    LP_WK_S = 7'h20,
    LP_WK_D = 7'h40
  } slpc_lps_t;

  function automatic logic [LST_W-1:0] lps_code(input slpc_lps_t s);
    logic [LST_W-1:0] c;
    c = 3'h4;
    unique case (s)
      LP_ACT:  c = 3'h0;
      LP_PART: c = 3'h1;
      LP_SLUM: c = 3'h2;
      LP_DSLP: c = 3'h3;
      default: c = 3'h4;
    endcase
    return c;
  endfunction

  function automatic logic lps_low(input slpc_lps_t s);
    return (s == LP_PART) || (s == LP_SLUM) || (s == LP_DSLP);
  endfunction

endpackage

// File: hdl/slpc_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module slpc_sync3
  import slpc_pkg::*;
#(
  parameter int W = 1
)
(
  // Clocking
  input  wire logic         SYS_CLK,
  input  wire logic         RST_N,
  input  wire logic         CE,
  // Data
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // A bit only moves once the two late stages agree, filtering one-cycle glitches
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end
    else if (CE)
    begin
      s1_r <= D;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign Q = q_r;

endmodule
`default_nettype wire

// File: hdl/slpc_top.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module slpc_top
  import slpc_pkg::*;
#(
  parameter int NPORTS      = 4,
  parameter int SLUMBER_CYC = SLUMBER_EXIT_CYC,
  parameter int DEVSLP_CYC  = DEVSLP_EXIT_CYC,
  parameter int IDLE_CYC    = DEVSLP_IDLE_CYC
)
(
  // Clocking
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  // Register port
  input  wire logic [7:0]        ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  input  wire logic              CFG_SPACE,
  output logic      [31:0]       RDATA,
  output logic                   MASTER_ABORT,
  // Interrupt gating
  input  wire logic              IRQ_PEND,
  output logic                   IRQ,
  // Command side
  output logic      [NPORTS-1:0] CMD_GO,
  // Link pins from the drive side
  input  wire logic [NPORTS-1:0] PRESENT,
  input  wire logic [NPORTS-1:0] PHY_RDY,
  input  wire logic [NPORTS-1:0] RX_REQ_PARTIAL,
  input  wire logic [NPORTS-1:0] RX_REQ_SLUMBER,
  input  wire logic [NPORTS-1:0] RX_COMWAKE,
  // Link controls toward the PHY
  output logic      [NPORTS-1:0] TX_PM_ACK,
  output logic      [NPORTS-1:0] TX_COMWAKE,
  output logic      [NPORTS-1:0] DEVSLP,
  output logic      [NPORTS-1:0] WIRE_OE_N,
  output logic      [NPORTS-1:0] PHY_GATE,
  output logic      [NPORTS-1:0] PLL_OFF
);

  localparam logic [CNT_W-1:0] PART_LIM  = CNT_W'(PARTIAL_EXIT_CYC);
  localparam logic [CNT_W-1:0] SLUM_LIM  = CNT_W'(SLUMBER_CYC);
  localparam logic [CNT_W-1:0] DSLP_LIM  = CNT_W'(DEVSLP_CYC);
  localparam logic [CNT_W-1:0] IDLE_LIM  = CNT_W'(IDLE_CYC);
  localparam logic [CNT_W-1:0] MS_CYC    = CNT_W'(CYC_PER_MS);

  // Synchronised link inputs
  logic [NPORTS-1:0] pres_s;
  logic [NPORTS-1:0] rdy_s;
  logic [NPORTS-1:0] reqp_s;
  logic [NPORTS-1:0] reqs_s;
  logic [NPORTS-1:0] wake_s;

  slpc_sync3 #(.W(5 * NPORTS)) u_sync (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .CE      (CE),
    .D       ({PRESENT, PHY_RDY, RX_REQ_PARTIAL, RX_REQ_SLUMBER, RX_COMWAKE}),
    .Q       ({pres_s, rdy_s, reqp_s, reqs_s, wake_s})
  );

  // Register state
  logic [CTRL_W-1:0] ctrl_r,   ctrl_nxt;
  logic [NPORTS-1:0] pgate_r,  pgate_nxt;
  logic [NPORTS-1:0] hp_r,     hp_nxt;
  logic [NPORTS-1:0] tmo_r,    tmo_nxt;
  logic [NPORTS-1:0] prev_r,   prev_nxt;
  logic [7:0]        dsexit_r, dsexit_nxt;
  logic [1:0]        pm_r,     pm_nxt;
  logic [31:0]       rdata_r,  rdata_nxt;
  logic              abort_r,  abort_nxt;
  logic              irq_r,    irq_nxt;
  logic [NPORTS-1:0] cmd_set;

  // Link state
  slpc_lps_t         st_r   [NPORTS];
  slpc_lps_t         st_nxt [NPORTS];
  logic [CNT_W-1:0]  cnt_r  [NPORTS];
  logic [CNT_W-1:0]  cnt_nxt[NPORTS];
  logic [NPORTS-1:0] pend_r, pend_nxt;
  logic [NPORTS-1:0] go_r,   go_nxt;
  logic [NPORTS-1:0] ack_r,  ack_nxt;
  logic [NPORTS-1:0] cw_r,   cw_nxt;
  logic [NPORTS-1:0] tmo_set;

  logic              d3;
  logic              acc_ok;
  logic              auto_ds;
  logic [CNT_W-1:0]  ds_lim;
  logic [NPORTS-1:0] pres_eff;

  assign d3       = (pm_r == PM_D3);
  // Register access; the power control word lives in config space only
  assign acc_ok   = CFG_SPACE ? (ADDR == OFS_PMCSR) : !d3;
  assign auto_ds  = ctrl_r[CTRL_DEVSLP_AUTO] &&
                    (ctrl_r[CTRL_HIPM] || ctrl_r[CTRL_DIPM]);
  // Drive-reported exit time replaces the default when non-zero
  assign ds_lim   = (dsexit_r != 8'h00) ? CNT_W'(dsexit_r * MS_CYC) : DSLP_LIM;
  assign pres_eff = d3 ? '0 : pres_s;

  function automatic logic [CNT_W-1:0] wake_lim(input slpc_lps_t s, input logic [CNT_W-1:0] dl);
    logic [CNT_W-1:0] l;
    l = SLUM_LIM;
    if (s == LP_WK_P)
    begin
      l = PART_LIM;
    end
    else if (s == LP_WK_D)
    begin
      l = dl;
    end
    return l;
  endfunction

  // Register port
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    pgate_nxt  = pgate_r;
    dsexit_nxt = dsexit_r;
    pm_nxt     = pm_r;
    rdata_nxt  = '0;
    abort_nxt  = (WR || RD) && !acc_ok;
    cmd_set    = '0;
    prev_nxt   = pres_eff;
    // Hardware set is applied after the write-one clear so an event is never lost
    hp_nxt     = hp_r;
    tmo_nxt    = tmo_r;
    if (WR && acc_ok && !CFG_SPACE && ADDR == OFS_HPSTAT)
    begin
      hp_nxt  = hp_r & ~WDATA[NPORTS-1:0];
      tmo_nxt = tmo_r & ~WDATA[HP_TMO_LSB +: NPORTS];
    end
    hp_nxt  = hp_nxt | (pres_eff ^ prev_r);
    tmo_nxt = tmo_nxt | tmo_set;
    if (WR && acc_ok)
    begin
      unique case (ADDR)
        OFS_CTRL:   ctrl_nxt   = WDATA[CTRL_W-1:0];
        OFS_PGATE:  pgate_nxt  = WDATA[NPORTS-1:0];
        OFS_CMD:    cmd_set    = WDATA[NPORTS-1:0];
        OFS_DSEXIT: dsexit_nxt = WDATA[7:0];
        OFS_PMCSR:  pm_nxt     = CFG_SPACE ? WDATA[1:0] : pm_r;
        default:    ;
      endcase
    end
    if (RD && acc_ok)
    begin
      unique case (ADDR)
        OFS_CTRL:   rdata_nxt[CTRL_W-1:0] = ctrl_r;
        OFS_PGATE:  rdata_nxt[NPORTS-1:0] = pgate_r;
        OFS_LSTATE:
        begin
          for (int i = 0; i < NPORTS; i++)
          begin
            rdata_nxt[i*LST_W +: LST_W] = lps_code(st_r[i]);
          end
        end
        OFS_HPSTAT:
        begin
          rdata_nxt[NPORTS-1:0]               = hp_r;
          rdata_nxt[HP_PRES_LSB +: NPORTS]    = pres_eff;
          rdata_nxt[HP_TMO_LSB +: NPORTS]     = tmo_r;
        end
        OFS_CAP:
        begin
          // The three link rates are advertised; RAID reads as available in RAID mode without the AHCI override
          rdata_nxt[2:0]            = CAP_SPEEDS;
          rdata_nxt[CAP_RAID_AVAIL] = ctrl_r[CTRL_RAID_MODE] &&
                                      !ctrl_r[CTRL_RAID_AHCI_OVR];
        end
        OFS_DSEXIT: rdata_nxt[7:0] = dsexit_r;
        OFS_PMCSR:  rdata_nxt[1:0] = CFG_SPACE ? pm_r : 2'h0;
        default:    ;
      endcase
    end
    // Pending status survives D3 and may fire once back in D0
    irq_nxt = IRQ_PEND && !d3;
  end

  // Per-port link power machine
  always_comb
  begin
    pend_nxt = pend_r | cmd_set;
    go_nxt   = '0;
    ack_nxt  = '0;
    cw_nxt   = '0;
    tmo_set  = '0;
    for (int i = 0; i < NPORTS; i++)
    begin
      st_nxt[i]  = st_r[i];
      cnt_nxt[i] = cnt_r[i];
      // In D3 the ports freeze; nothing is reset so D0 resumes where it stopped
      if (!d3)
      begin
        unique case (st_r[i])
          LP_ACT:
          begin
            cnt_nxt[i] = '0;
            if (pend_r[i])
            begin
              go_nxt[i]   = 1'b1;
              pend_nxt[i] = cmd_set[i];
            end
            // Partial and slumber are entered only on the drive's request, never by us
            else if (reqs_s[i])
            begin
              ack_nxt[i] = 1'b1;
              st_nxt[i]  = LP_SLUM;
            end
            else if (reqp_s[i])
            begin
              ack_nxt[i] = 1'b1;
              st_nxt[i]  = LP_PART;
            end
          end
          LP_PART:
          begin
            cnt_nxt[i] = '0;
            if (pend_r[i])
            begin
              cw_nxt[i] = 1'b1;
              st_nxt[i] = LP_WK_P;
            end
            else if (wake_s[i])
            begin
              st_nxt[i] = LP_WK_P;
            end
          end
          LP_SLUM:
          begin
            if (pend_r[i])
            begin
              cw_nxt[i]  = 1'b1;
              cnt_nxt[i] = '0;
              st_nxt[i]  = LP_WK_S;
            end
            // With PLLs off the drive's wake cannot be seen
            else if (wake_s[i] && !ctrl_r[CTRL_LOW_POWER])
            begin
              cnt_nxt[i] = '0;
              st_nxt[i]  = LP_WK_S;
            end
            else if (auto_ds && cnt_r[i] >= IDLE_LIM)
            begin
              st_nxt[i] = LP_DSLP;
            end
            else if (cnt_r[i] < IDLE_LIM)
            begin
              cnt_nxt[i] = cnt_r[i] + 1'b1;
            end
          end
          LP_DSLP:
          begin
            cnt_nxt[i] = '0;
            if (pend_r[i])
            begin
              cw_nxt[i] = 1'b1;
              st_nxt[i] = LP_WK_D;
            end
          end
          LP_WK_P, LP_WK_S, LP_WK_D:
          begin
            // Waking: a late PHY is flagged but still waited for
            if (rdy_s[i])
            begin
              st_nxt[i]  = LP_ACT;
              cnt_nxt[i] = '0;
            end
            else if (cnt_r[i] >= wake_lim(st_r[i], ds_lim))
            begin
              tmo_set[i] = 1'b1;
            end
            else
            begin
              cnt_nxt[i] = cnt_r[i] + 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      ctrl_r   <= '0;
      pgate_r  <= '0;
      hp_r     <= '0;
      tmo_r    <= '0;
      prev_r   <= '0;
      dsexit_r <= 8'h00;
      pm_r     <= PM_D0;
      rdata_r  <= '0;
      abort_r  <= 1'b0;
      irq_r    <= 1'b0;
      pend_r   <= '0;
      go_r     <= '0;
      ack_r    <= '0;
      cw_r     <= '0;
      for (int i = 0; i < NPORTS; i++)
      begin
        st_r[i]  <= LP_ACT;
        cnt_r[i] <= '0;
      end
    end
    else if (CE)
    begin
      ctrl_r   <= ctrl_nxt;
      pgate_r  <= pgate_nxt;
      hp_r     <= hp_nxt;
      tmo_r    <= tmo_nxt;
      prev_r   <= prev_nxt;
      dsexit_r <= dsexit_nxt;
      pm_r     <= pm_nxt;
      rdata_r  <= rdata_nxt;
      abort_r  <= abort_nxt;
      irq_r    <= irq_nxt;
      pend_r   <= pend_nxt;
      go_r     <= go_nxt;
      ack_r    <= ack_nxt;
      cw_r     <= cw_nxt;
      for (int i = 0; i < NPORTS; i++)
      begin
        st_r[i]  <= st_nxt[i];
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  // Outputs
  always_comb
  begin
    for (int i = 0; i < NPORTS; i++)
    begin
      DEVSLP[i]    = (st_r[i] == LP_DSLP);
      PHY_GATE[i]  = pgate_r[i] && lps_low(st_r[i]);
      PLL_OFF[i]   = d3 || (ctrl_r[CTRL_LOW_POWER] &&
                     (st_r[i] == LP_SLUM || st_r[i] == LP_DSLP));
      WIRE_OE_N[i] = d3;
    end
  end

  assign RDATA        = rdata_r;
  assign MASTER_ABORT = abort_r;
  assign IRQ          = irq_r;
  assign CMD_GO       = go_r;
  assign TX_PM_ACK    = ack_r;
  assign TX_COMWAKE   = cw_r;

endmodule
`default_nettype wire

// File: bench/slpc_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
module slpc_drive_model
#(
  parameter int NP = 4
)
(
  // Clock and bench controls
  input  wire logic          clk,
  input  wire logic [NP-1:0] go_part,
  input  wire logic [NP-1:0] go_slum,
  input  wire logic [NP-1:0] go_wake,
  input  wire logic          slow,
  // From host
  input  wire logic [NP-1:0] pm_ack,
  input  wire logic [NP-1:0] comwake,
  input  wire logic [NP-1:0] devslp,
  // To host
  output logic      [NP-1:0] present,
  output logic      [NP-1:0] phy_rdy,
  output logic      [NP-1:0] req_part,
  output logic      [NP-1:0] req_slum,
  output logic      [NP-1:0] rx_wake
);
  int            cnt [NP];
  int            wk [NP];
  logic [NP-1:0] dslp_q;
  logic [NP-1:0] resume;

  // Never drops to standby; present is tied high whatever the host sends
  assign present = '1;
  assign resume = dslp_q & ~devslp;
  initial
  begin
    phy_rdy = '1;
    req_part = '0;
    req_slum = '0;
    rx_wake = '0;
    dslp_q = '0;
  end
  // Requests stay up until acknowledged, as a real drive keeps retrying
  always @(posedge clk)
  begin
    dslp_q <= devslp;
    for (int i = 0; i < NP; i++)
    begin
      rx_wake[i] <= wk[i] > 0;
      wk[i] <= (wk[i] > 0) ? wk[i] - 1 : 0;
      cnt[i] <= (cnt[i] > 0) ? cnt[i] - 1 : 0;
      if (cnt[i] == 1)
        phy_rdy[i] <= 1'b1;
      if (go_part[i])
        req_part[i] <= 1'b1;
      if (go_slum[i])
        req_slum[i] <= 1'b1;
      if (pm_ack[i])
      begin
        req_part[i] <= 1'b0;
        req_slum[i] <= 1'b0;
        phy_rdy[i] <= 1'b0;
      end
      if (go_wake[i] || resume[i])
        wk[i] <= 3;
      if (go_wake[i] || resume[i] || comwake[i])
        cnt[i] <= slow ? 40 : 3;
    end
  end
endmodule
`default_nettype wire

// File: bench/slpc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module slpc_top_sva
  import slpc_pkg::*;
#(
  parameter int NPORTS = 4
)
(
  // Clocking
  input wire logic              SYS_CLK,
  input wire logic              RST_N,
  // Register port
  input wire logic [7:0]        ADDR,
  input wire logic [31:0]       WDATA,
  input wire logic              WR,
  input wire logic              RD,
  input wire logic              CFG_SPACE,
  input wire logic [31:0]       RDATA,
  input wire logic              MASTER_ABORT,
  input wire logic              IRQ_PEND,
  input wire logic              IRQ,
  // Link
  input wire logic [NPORTS-1:0] CMD_GO,
  input wire logic [NPORTS-1:0] RX_REQ_PARTIAL,
  input wire logic [NPORTS-1:0] RX_REQ_SLUMBER,
  input wire logic [NPORTS-1:0] RX_COMWAKE,
  input wire logic [NPORTS-1:0] TX_PM_ACK,
  input wire logic [NPORTS-1:0] TX_COMWAKE,
  input wire logic [NPORTS-1:0] DEVSLP,
  input wire logic [NPORTS-1:0] WIRE_OE_N
);
  logic              d3_r, d3_nxt, pmw, slum_r, slum_nxt;
  logic [NPORTS-1:0] pend_r, pend_nxt, reqs, cmd_wr;

  assign reqs = RX_REQ_PARTIAL | RX_REQ_SLUMBER;
  assign pmw = WR && CFG_SPACE && ADDR == OFS_PMCSR;
  assign cmd_wr = (WR && !CFG_SPACE && !d3_r && ADDR == OFS_CMD) ? WDATA[NPORTS-1:0] : '0;
  // Power state and pending commands as software sees them
  always_comb
  begin
    d3_nxt = pmw ? (WDATA[1:0] == PM_D3) : d3_r;
    pend_nxt = (pend_r | cmd_wr) & ~CMD_GO;
    slum_nxt = TX_PM_ACK[1] ? RX_REQ_SLUMBER[1] : slum_r & ~TX_COMWAKE[1] & ~RX_COMWAKE[1];
  end
  always_ff @(posedge SYS_CLK)
  begin
    d3_r <= RST_N & d3_nxt;
    pend_r <= RST_N ? pend_nxt : '0;
    slum_r <= RST_N & slum_nxt;
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  a_irq_off_d3: assert property (d3_r && !pmw |=> !IRQ)
    else $error("interrupt while powered down");
  a_irq_on_d0: assert property (RST_N && !d3_r && !pmw && IRQ_PEND |=> IRQ)
    else $error("interrupt lost while running");
  a_abort_d3: assert property (d3_r && (WR || RD) && !CFG_SPACE |=> MASTER_ABORT)
    else $error("access not aborted while powered down");
  a_cfg_taken: assert property ((WR || RD) && CFG_SPACE && ADDR == OFS_PMCSR |=> !MASTER_ABORT)
    else $error("config access aborted");
  a_ack_cause: assert property ((TX_PM_ACK & ~$past(reqs, 3)) == '0)
    else $error("power request ack without request");
  a_wake_cause: assert property ((TX_COMWAKE & ~pend_r) == '0)
    else $error("wake sent with no command waiting");
  a_wires_free: assert property (d3_r && !pmw |=> WIRE_OE_N == {NPORTS{1'b1}})
    else $error("wires still driven while powered down");
  a_dslp_entry: assert property ($rose(DEVSLP[1]) |-> slum_r)
    else $error("device sleep entered outside slumber");
  a_cap_speeds: assert property (RD && ADDR == OFS_CAP && !CFG_SPACE && !d3_r
                                 |=> RDATA[2:0] == CAP_SPEEDS)
    else $error("link speed capability wrong");

  c_d3_pend: cover property (d3_r && IRQ_PEND);
  c_dslp: cover property ($rose(DEVSLP[1]));
  c_wake: cover property (TX_COMWAKE[0]);
endmodule

bind slpc_top slpc_top_sva #(.NPORTS(NPORTS)) sva_u (.SYS_CLK, .RST_N, .ADDR, .WDATA, .WR,
  .RD, .CFG_SPACE, .RDATA, .MASTER_ABORT, .IRQ_PEND, .IRQ, .CMD_GO, .RX_REQ_PARTIAL,
  .RX_REQ_SLUMBER, .RX_COMWAKE, .TX_PM_ACK, .TX_COMWAKE, .DEVSLP, .WIRE_OE_N);
`default_nettype wire

// File: bench/slpc_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module slpc_top_tb_top
  import slpc_pkg::*;
;
  typedef struct {logic w; logic c; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic ab;} slpc_row_t;
  logic        SYS_CLK, MASTER_ABORT, IRQ, ab, RST_N = 0, CE = 1, WR = 0, RD = 0;
  logic        CFG_SPACE = 0, IRQ_PEND = 0, slow = 0;
  logic [7:0]  ADDR = 8'h0;
  logic [31:0] WDATA = 32'h0, RDATA, q;
  logic [3:0]  CMD_GO, PRESENT, PHY_RDY, RX_REQ_PARTIAL, RX_REQ_SLUMBER, RX_COMWAKE;
  logic [3:0]  TX_PM_ACK, TX_COMWAKE, DEVSLP, WIRE_OE_N, PHY_GATE, PLL_OFF;
  logic [3:0]  go_part = 4'h0, go_slum = 4'h0, go_wake = 4'h0;
  int          miscompares = 0, num_checks = 0;
  slpc_row_t   rows [13] = '{
    '{1, 0, OFS_CTRL, 32'h1, 32'h0, 0},
    '{0, 0, OFS_CAP, 32'h0, 32'hf, 0},
    '{1, 0, OFS_CTRL, 32'h3, 32'h0, 0},
    '{0, 0, OFS_CAP, 32'h0, 32'h7, 0},
    '{0, 0, OFS_CTRL, 32'h0, 32'h3, 0},
    '{1, 0, OFS_PGATE, 32'h5, 32'h0, 0},
    '{0, 0, OFS_PGATE, 32'h0, 32'h5, 0},
    '{0, 0, 8'h20, 32'h0, 32'h0, 0},
    '{0, 0, OFS_LSTATE, 32'h0, 32'h0, 0},
    '{0, 1, OFS_LSTATE, 32'h0, 32'h0, 1},
    '{0, 1, OFS_PMCSR, 32'h0, 32'h0, 0},
    '{1, 0, OFS_HPSTAT, 32'hf, 32'h0, 0},
    '{0, 0, OFS_HPSTAT, 32'h0, 32'hf00, 0}
  };

  slpc_top #(.NPORTS(4), .SLUMBER_CYC(50), .DEVSLP_CYC(100), .IDLE_CYC(8)) dut_u (.SYS_CLK,
    .RST_N, .CE, .ADDR, .WDATA, .WR, .RD, .CFG_SPACE, .RDATA, .MASTER_ABORT, .IRQ_PEND, .IRQ,
    .CMD_GO, .PRESENT, .PHY_RDY, .RX_REQ_PARTIAL, .RX_REQ_SLUMBER, .RX_COMWAKE, .TX_PM_ACK,
    .TX_COMWAKE, .DEVSLP, .WIRE_OE_N, .PHY_GATE, .PLL_OFF);
  slpc_drive_model #(.NP(4)) drv_u (.clk(SYS_CLK), .go_part, .go_slum, .go_wake, .slow,
    .pm_ack(TX_PM_ACK), .comwake(TX_COMWAKE), .devslp(DEVSLP), .present(PRESENT),
    .phy_rdy(PHY_RDY), .req_part(RX_REQ_PARTIAL), .req_slum(RX_REQ_SLUMBER), .rx_wake(RX_COMWAKE));

  initial
  begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // One bus access; read data and abort are taken in the cycle after the strobe
  task automatic acc(input logic w, input logic c, input logic [7:0] a, input logic [31:0] d);
    WR <= w;
    RD <= !w;
    CFG_SPACE <= c;
    ADDR <= a;
    WDATA <= d;
    @(posedge SYS_CLK);
    WR <= 1'b0;
    RD <= 1'b0;
    @(negedge SYS_CLK);
    q = RDATA;
    ab = MASTER_ABORT;
    @(posedge SYS_CLK);
  endtask

  task automatic rd(input logic c, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, c, a, 32'h0);
    chk(q, e);
  endtask

  // Pulses are sampled mid-cycle so the launching edge has settled
  task automatic wait_hi(input int s, input int p, input int lim);
    logic [3:0] v;
    int         n;
    n = 0;
    do
    begin
      @(negedge SYS_CLK);
      v = (s == 0) ? TX_PM_ACK : (s == 1) ? TX_COMWAKE : (s == 2) ? CMD_GO : DEVSLP;
      n++;
    end
    while (v[p] !== 1'b1 && n < lim);
    chk(32'(v[p]), 32'h1);
    @(posedge SYS_CLK);
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    foreach (rows[i])
    begin
      acc(rows[i].w, rows[i].c, rows[i].a, rows[i].d);
      chk(q, rows[i].q);
      chk(32'(ab), 32'(rows[i].ab));
    end
    // Partial on port 0, a command wakes it
    go_part <= 4'h1;
    @(posedge SYS_CLK);
    go_part <= 4'h0;
    wait_hi(0, 0, 20);
    rd(1'b0, OFS_LSTATE, 32'h1);
    acc(1'b1, 1'b0, OFS_CMD, 32'h1);
    wait_hi(1, 0, 5);
    wait_hi(2, 0, 20);
    rd(1'b0, OFS_HPSTAT, 32'h10f00);
    acc(1'b1, 1'b0, OFS_HPSTAT, 32'h10000);
    // Slumber on port 1 falls into device sleep, then a command wakes it
    acc(1'b1, 1'b0, OFS_CTRL, 32'h28);
    go_slum <= 4'h2;
    @(posedge SYS_CLK);
    go_slum <= 4'h0;
    wait_hi(0, 1, 20);
    wait_hi(3, 1, 40);
    rd(1'b0, OFS_LSTATE, 32'h18);
    acc(1'b1, 1'b0, OFS_CMD, 32'h2);
    wait_hi(2, 1, 120);
    rd(1'b0, OFS_HPSTAT, 32'hf00);
    // A command wakes port 2 from slumber; the slow drive is ready inside the limit
    acc(1'b1, 1'b0, OFS_CTRL, 32'h0);
    slow <= 1'b1;
    go_slum <= 4'h4;
    @(posedge SYS_CLK);
    go_slum <= 4'h0;
    wait_hi(0, 2, 20);
    // Let the stale ready from before the request drain through the filter
    rd(1'b0, OFS_LSTATE, 32'h80);
    chk(32'(PHY_GATE), 32'h4);
    acc(1'b1, 1'b0, OFS_CMD, 32'h4);
    wait_hi(1, 2, 5);
    wait_hi(2, 2, 80);
    rd(1'b0, OFS_HPSTAT, 32'hf00);
    slow <= 1'b0;
    // Drive wakes port 3 from partial; polled until every port reads back as active
    go_part <= 4'h8;
    @(posedge SYS_CLK);
    go_part <= 4'h0;
    wait_hi(0, 3, 20);
    go_wake <= 4'h8;
    @(posedge SYS_CLK);
    go_wake <= 4'h0;
    q = 32'h1;
    for (int n = 0; n < 20 && q !== 32'h0; n++)
      acc(1'b0, 1'b0, OFS_LSTATE, 32'h0);
    chk(q, 32'h0);
    // Low power: port 3 in slumber stops its PLL
    acc(1'b1, 1'b0, OFS_CTRL, 32'h4);
    go_slum <= 4'h8;
    @(posedge SYS_CLK);
    go_slum <= 4'h0;
    wait_hi(0, 3, 20);
    rd(1'b0, OFS_LSTATE, 32'h400);
    chk(32'(PLL_OFF), 32'h8);
    // Powered down with an interrupt pending, then back up
    IRQ_PEND <= 1'b1;
    acc(1'b1, 1'b1, OFS_PMCSR, 32'h3);
    @(negedge SYS_CLK);
    chk(32'(IRQ), 32'h0);
    chk(32'(WIRE_OE_N), 32'hf);
    chk(32'(PLL_OFF), 32'hf);
    @(posedge SYS_CLK);
    rd(1'b0, OFS_CTRL, 32'h0);
    chk(32'(ab), 32'h1);
    rd(1'b1, OFS_PMCSR, 32'h3);
    chk(32'(ab), 32'h0);
    acc(1'b1, 1'b0, OFS_CTRL, 32'h3f);
    acc(1'b1, 1'b1, OFS_PMCSR, 32'h0);
    @(negedge SYS_CLK);
    chk(32'(IRQ), 32'h1);
    @(posedge SYS_CLK);
    rd(1'b0, OFS_CTRL, 32'h4);
    rd(1'b0, OFS_PGATE, 32'h5);
    // Second reset in mid-run clears the registers
    RST_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    rd(1'b0, OFS_PGATE, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
